/* File: rtl/ascr_pkg.sv */
/*
  Package for the amplifier system control register bank.
  Holds register offsets, field positions, reset values and carrier structs.
  Assumes a 32-bit APB master; each 8-bit register sits in one aligned word.
*/
package ascr_pkg;

  // Register indexes (byte offsets are all multiples of four)
  localparam logic [7:0] IDX_IDENT   = 8'h01;
  localparam logic [7:0] IDX_ERR     = 8'h02;
  localparam logic [7:0] IDX_SYS1    = 8'h03;
  localparam logic [7:0] IDX_FMT     = 8'h04;
  localparam logic [7:0] IDX_SYS2    = 8'h05;
  localparam logic [7:0] IDX_IRQMASK = 8'h06;

  // Byte addresses are four times the index
  localparam logic [11:0] ADDR_IDENT   = {2'h0, IDX_IDENT, 2'h0};
  localparam logic [11:0] ADDR_ERR     = {2'h0, IDX_ERR, 2'h0};
  localparam logic [11:0] ADDR_SYS1    = {2'h0, IDX_SYS1, 2'h0};
  localparam logic [11:0] ADDR_FMT     = {2'h0, IDX_FMT, 2'h0};
  localparam logic [11:0] ADDR_SYS2    = {2'h0, IDX_SYS2, 2'h0};
  localparam logic [11:0] ADDR_IRQMASK = {2'h0, IDX_IRQMASK, 2'h0};

  // Identification code, value arbitrary
  localparam logic [7:0] IDENT_CODE = 8'h5a;

  // Writable bit masks; other bits are reserved and read zero
  localparam logic [7:0] ERR_MASK  = 8'h78;
  localparam logic [7:0] SYS1_MASK = 8'haf;
  localparam logic [7:0] FMT_MASK  = 8'h1f;
  localparam logic [7:0] SYS2_MASK = 8'h6e;

  // Reset values
  localparam logic [7:0] SYS1_RST = 8'ha0;
  localparam logic [7:0] FMT_RST  = 8'h05;
  localparam logic [7:0] SYS2_RST = 8'h40;

  // Field positions
  localparam int ERR_LOCK   = 6;
  localparam int ERR_BCLK   = 5;
  localparam int ERR_WCLK   = 4;
  localparam int ERR_SLIP   = 3;
  localparam int S1_DCBLK   = 7;
  localparam int S1_HARDUM  = 5;
  localparam int S1_NOAUTO  = 3;
  localparam int S1_NOSOFT  = 2;
  localparam int S1_DEEM_HI = 1;
  localparam int S1_DEEM_LO = 0;
  localparam int S2_STOP    = 6;
  localparam int S2_ALLCH   = 5;
  localparam int S2_VOLSRC  = 3;
  localparam int S2_MODE_HI = 2;
  localparam int S2_MODE_LO = 1;

  // De-emphasis codes
  localparam logic [1:0] DEEM_NONE = 2'h0;
  localparam logic [1:0] DEEM_RSV  = 2'h1;
  localparam logic [1:0] DEEM_44K  = 2'h2;
  localparam logic [1:0] DEEM_48K  = 2'h3;

  // Output mode codes
  localparam logic [1:0] MODE_SPK  = 2'h0;
  localparam logic [1:0] MODE_HP   = 2'h1;
  localparam logic [1:0] MODE_LINE = 2'h2;

  // Serial format codes
  localparam logic [4:0] FMT_RJ16   = 5'h00;
  localparam logic [4:0] FMT_RJ20   = 5'h01;
  localparam logic [4:0] FMT_RJ24   = 5'h02;
  localparam logic [4:0] FMT_I2S16  = 5'h03;
  localparam logic [4:0] FMT_I2S20  = 5'h04;
  localparam logic [4:0] FMT_I2S24  = 5'h05;
  localparam logic [4:0] FMT_LJ16   = 5'h06;
  localparam logic [4:0] FMT_LJ20   = 5'h07;
  localparam logic [4:0] FMT_LJ24   = 5'h08;
  localparam logic [4:0] FMT_RJ18   = 5'h0a;
  localparam logic [4:0] FMT_I2S32F = 5'h13;
  localparam logic [4:0] FMT_LJ32F  = 5'h16;

  // Justification kinds
  typedef enum logic [1:0] {
    JUST_RIGHT,
    JUST_I2S,
    JUST_LEFT
  } ascr_just_t;

  // Word lengths in bits
  localparam logic [4:0] WL16 = 5'd16;
  localparam logic [4:0] WL18 = 5'd18;
  localparam logic [4:0] WL20 = 5'd20;
  localparam logic [4:0] WL24 = 5'd24;

  // Error events from the audio core
  typedef struct packed {
    logic lock_lost;
    logic bclk_fault;
    logic wclk_fault;
    logic frame_slip;
  } ascr_err_t;

  // Decoded serial format
  typedef struct packed {
    ascr_just_t just;
    logic [4:0] word_len;
    logic       bclk_32fs;
    logic       reserved;
  } ascr_fmt_t;

  // Decoded control seen by the audio core
  typedef struct packed {
    logic       dc_block_en;
    logic       hard_unmute;
    logic       autodetect_en;
    logic       soft_start_en;
    logic [1:0] deemph;
    logic       deemph_rsv;
    logic       play;
    logic       outputs_valid;
    logic       all_channels;
    logic       hp_vol_own;
    logic       hp_active;
    logic       line_out;
    logic       spk_mute;
    logic       mode_rsv;
  } ascr_ctl_t;

endpackage : ascr_pkg

/* File: rtl/ascr_regs.sv */
/*
  Amplifier system control register bank with APB slave.
  Assumes error events are single-cycle pulses on the clock domain and the
  headphone select pin is asynchronous.
*/
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module ascr_regs
  import ascr_pkg::*;
(
  input  wire logic        clock,                // 10 MHz system clock
  input  wire logic        rst_b,                // Synchronous reset, active low
  input  wire logic        psel,                 // APB select
  input  wire logic        penable,              // APB access phase
  input  wire logic        pwrite,               // APB direction
  input  wire logic [11:0] paddr,                // APB byte address
  input  wire logic [31:0] pwdata,               // APB write data
  output logic      [31:0] prdata,               // APB read data
  output logic             pready,               // APB ready
  output logic             pslverr,              // APB error
  input  wire ascr_err_t   err_events,           // Error event pulses
  input  wire logic        headphone_select_pin, // Asynchronous pin
  output ascr_ctl_t        ctl,                  // Decoded control
  output ascr_fmt_t        fmt,                  // Decoded serial format
  output logic             irq                   // Level interrupt
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] err_q, err_d;     // Sticky error flags
  logic [7:0] mask_q, mask_d;   // Interrupt mask
  logic [7:0] sys1_q, sys1_d;   // First system control
  logic [7:0] fmt_q, fmt_d;     // Serial format
  logic [7:0] sys2_q, sys2_d;   // Second system control
  logic [31:0] rdata_q, rdata_d; // Read data
  logic       slverr_q, slverr_d; // Error flag for the answer
  logic       hp_s1_q, hp_s2_q; // Pin synchroniser
  logic       wr_en;            // Write takes effect
  logic       rd_en;            // Read taken
  logic       hit;              // Address mapped
  logic [7:0] wbyte;            // Low write byte
  logic [7:0] ev_vec;           // Event pulses in flag layout
  logic       hp_forced;        // Register forces headphone mode
  ascr_ctl_t  ctl_d;            // Next decoded control
  ascr_fmt_t  fmt_d2;           // Next decoded format

  ////////////////////////////////////////////////////////////////////////
  // Bus decode; setup cycle then one access cycle, ready always high
  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign wbyte   = pwdata[7:0];
  assign prdata  = rdata_q;
  assign pslverr = slverr_q & psel & penable;

  // Address hit
  always_comb begin
    case (paddr)
      ADDR_IDENT, ADDR_ERR, ADDR_SYS1, ADDR_FMT, ADDR_SYS2, ADDR_IRQMASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Event vector in flag layout
  always_comb begin
    ev_vec           = 8'h00;
    ev_vec[ERR_LOCK] = err_events.lock_lost;
    ev_vec[ERR_BCLK] = err_events.bclk_fault;
    ev_vec[ERR_WCLK] = err_events.wclk_fault;
    ev_vec[ERR_SLIP] = err_events.frame_slip;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register next values
  always_comb begin
    err_d  = err_q;
    mask_d = mask_q;
    sys1_d = sys1_q;
    fmt_d  = fmt_q;
    sys2_d = sys2_q;
    // Any host write to the flag register clears every flag
    if (wr_en && paddr == ADDR_ERR) begin
      err_d = 8'h00;
    end
    // Set wins over clear, flags stay until software clears
    err_d = (err_d | ev_vec) & ERR_MASK;
    if (wr_en) begin
      case (paddr)
        // Reserved bits masked off on write
        ADDR_SYS1:    sys1_d = wbyte & SYS1_MASK;
        ADDR_FMT:     fmt_d  = wbyte & FMT_MASK;
        ADDR_SYS2:    sys2_d = wbyte & SYS2_MASK;
        ADDR_IRQMASK: mask_d = wbyte & ERR_MASK;
        default:      ;     // Identification read-only; flag register write handled above
      endcase
    end
  end

  // Read data; taken in the setup cycle so it stands in the access cycle
  always_comb begin
    rdata_d  = rdata_q;
    slverr_d = 1'b0;
    if (psel && !penable) begin
      slverr_d = ~hit;
      rdata_d  = 32'h0000_0000;
      if (rd_en) begin
        case (paddr)
          ADDR_IDENT:   rdata_d[7:0] = IDENT_CODE;
          ADDR_ERR:     rdata_d[7:0] = err_q;
          ADDR_SYS1:    rdata_d[7:0] = sys1_q;
          ADDR_FMT:     rdata_d[7:0] = fmt_q;
          ADDR_SYS2:    rdata_d[7:0] = sys2_q;
          ADDR_IRQMASK: rdata_d[7:0] = mask_q;
          default:      rdata_d      = 32'h0000_0000;
        endcase
      end
    end
  end

  // Register storage
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      err_q    <= 8'h00;
      mask_q   <= 8'h00;
      sys1_q   <= SYS1_RST;
      fmt_q    <= FMT_RST;
      sys2_q   <= SYS2_RST;
      rdata_q  <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else begin
      err_q    <= err_d;
      mask_q   <= mask_d;
      sys1_q   <= sys1_d;
      fmt_q    <= fmt_d;
      sys2_q   <= sys2_d;
      rdata_q  <= rdata_d;
      slverr_q <= slverr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Headphone select pin synchroniser, two flops
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hp_s1_q <= 1'b0;
      hp_s2_q <= 1'b0;
    end else begin
      hp_s1_q <= headphone_select_pin;
      hp_s2_q <= hp_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control decode
  always_comb begin
    ctl_d = '0;
    ctl_d.dc_block_en   = sys1_q[S1_DCBLK];
    ctl_d.hard_unmute   = sys1_q[S1_HARDUM];
    // Autodetect active when bit is zero
    ctl_d.autodetect_en = ~sys1_q[S1_NOAUTO];
    // Soft start active when bit is zero
    ctl_d.soft_start_en = ~sys1_q[S1_NOSOFT];
    ctl_d.deemph_rsv    = (sys1_q[S1_DEEM_HI:S1_DEEM_LO] == DEEM_RSV);
    ctl_d.deemph        = ctl_d.deemph_rsv ? DEEM_NONE : sys1_q[S1_DEEM_HI:S1_DEEM_LO];
    // Stop bit shuts outputs and clears valid
    ctl_d.play          = ~sys2_q[S2_STOP];
    ctl_d.outputs_valid = ~sys2_q[S2_STOP];
    // All channels or all outside the shutdown group
    ctl_d.all_channels  = sys2_q[S2_ALLCH];
    // Headphone volume register used when bit is zero
    ctl_d.hp_vol_own    = ~sys2_q[S2_VOLSRC];
    // Output mode combined with the synchronised pin
    case (sys2_q[S2_MODE_HI:S2_MODE_LO])
      MODE_SPK:  ctl_d.hp_active = hp_s2_q;
      MODE_HP:   ctl_d.hp_active = 1'b1;
      MODE_LINE: begin
        ctl_d.hp_active = 1'b1;
        ctl_d.line_out  = 1'b1;
      end
      default:   ctl_d.mode_rsv = 1'b1;
    endcase
    // Headphone mode mutes the speaker outputs
    ctl_d.spk_mute = ctl_d.hp_active & ~ctl_d.line_out;
  end
  assign hp_forced = (sys2_q[S2_MODE_HI:S2_MODE_LO] == MODE_HP);

  // Serial format decode
  always_comb begin
    fmt_d2 = '{just: JUST_I2S, word_len: WL24, bclk_32fs: 1'b0, reserved: 1'b0};
    // Justification and word length from low five bits
    case (fmt_q[4:0])
      FMT_RJ16:   fmt_d2 = '{JUST_RIGHT, WL16, 1'b0, 1'b0};
      FMT_RJ20:   fmt_d2 = '{JUST_RIGHT, WL20, 1'b0, 1'b0};
      FMT_RJ24:   fmt_d2 = '{JUST_RIGHT, WL24, 1'b0, 1'b0};
      FMT_I2S16:  fmt_d2 = '{JUST_I2S, WL16, 1'b0, 1'b0};
      FMT_I2S20:  fmt_d2 = '{JUST_I2S, WL20, 1'b0, 1'b0};
      FMT_I2S24:  fmt_d2 = '{JUST_I2S, WL24, 1'b0, 1'b0};
      FMT_LJ16:   fmt_d2 = '{JUST_LEFT, WL16, 1'b0, 1'b0};
      FMT_LJ20:   fmt_d2 = '{JUST_LEFT, WL20, 1'b0, 1'b0};
      FMT_LJ24:   fmt_d2 = '{JUST_LEFT, WL24, 1'b0, 1'b0};
      FMT_RJ18:   fmt_d2 = '{JUST_RIGHT, WL18, 1'b0, 1'b0};
      // Bit clock of 32 times the sample rate
      FMT_I2S32F: fmt_d2 = '{JUST_I2S, WL16, 1'b1, 1'b0};
      FMT_LJ32F:  fmt_d2 = '{JUST_LEFT, WL16, 1'b1, 1'b0};
      default:    fmt_d2.reserved = 1'b1;  // Reserved: keep I2S 24-bit
    endcase
  end

  // Decoded outputs registered
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctl <= '0;
      fmt <= '{just: JUST_I2S, word_len: WL24, bclk_32fs: 1'b0, reserved: 1'b0};
    end else begin
      ctl <= ctl_d;
      fmt <= fmt_d2;
    end
  end

  // Interrupt level from unmasked sticky flags
  assign irq = |(err_q & mask_q);

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_err_sticky: assert property (@(posedge clock) disable iff (!rst_b)
    (err_events.frame_slip) |=> err_q[ERR_SLIP])
    else $error("frame slip flag not set");
  a_err_hold: assert property (@(posedge clock) disable iff (!rst_b)
    (err_q[ERR_LOCK] && !(wr_en && paddr == ADDR_ERR)) |=> err_q[ERR_LOCK])
    else $error("lock flag dropped without clear");
  a_err_clear: assert property (@(posedge clock) disable iff (!rst_b)
    (wr_en && paddr == ADDR_ERR && ev_vec == 8'h00) |=> err_q == 8'h00)
    else $error("error flags not cleared");
  a_dc_block: assert property (@(posedge clock) disable iff (!rst_b)
    $past(rst_b) |-> ctl.dc_block_en == $past(sys1_q[S1_DCBLK]))
    else $error("dc block enable mismatch");
  a_autodet: assert property (@(posedge clock) disable iff (!rst_b)
    (wr_en && paddr == ADDR_SYS1 && !wbyte[S1_NOAUTO]) |=> ##1 ctl.autodetect_en)
    else $error("autodetect not enabled");
  a_stop_mute: assert property (@(posedge clock) disable iff (!rst_b)
    sys2_q[S2_STOP] |=> !ctl.outputs_valid && !ctl.play)
    else $error("outputs valid while stopped");
  a_hp_mute: assert property (@(posedge clock) disable iff (!rst_b)
    hp_forced |=> ctl.spk_mute && ctl.hp_active)
    else $error("speakers not muted in headphone mode");
  a_fmt_32fs: assert property (@(posedge clock) disable iff (!rst_b)
    (fmt_q[4:0] == FMT_I2S32F) |=> fmt.bclk_32fs && fmt.word_len == WL16)
    else $error("32 fs format not decoded");
  a_ident_ro: assert property (@(posedge clock) disable iff (!rst_b)
    (rd_en && paddr == ADDR_IDENT) |=> prdata == {24'h000000, IDENT_CODE})
    else $error("identification code wrong");
  a_rsv_zero: assert property (@(posedge clock) disable iff (!rst_b)
    (sys2_q & ~SYS2_MASK) == 8'h00 && (fmt_q & ~FMT_MASK) == 8'h00)
    else $error("reserved bits not zero");
  c_err_event: cover property (@(posedge clock) disable iff (!rst_b)
    err_events.lock_lost ##1 irq);
  c_play: cover property (@(posedge clock) disable iff (!rst_b)
    ctl.play && ctl.all_channels);
  c_line_out: cover property (@(posedge clock) disable iff (!rst_b) ctl.line_out);

endmodule : ascr_regs

/* File: test/tb_amp_system_control_regs.sv */
/*
  Self-checking bench for the amplifier system control register bank.
  Assumes the bank answers APB with pready high and decodes ctl/fmt a few edges after a write.
*/
`timescale 1ns/1ps
module tb_amp_system_control_regs
  import ascr_pkg::*;
();
  ////////////////////////////////////////////////////////////////////////////////
  logic        clock;                // 10 MHz bench clock
  logic        rst_b;                // Synchronous reset, active low
  logic        psel;                 // APB select
  logic        penable;              // APB access phase
  logic        pwrite;               // APB direction
  logic [11:0] paddr;                // APB byte address
  logic [31:0] pwdata;               // APB write data
  logic [31:0] prdata;               // APB read data
  logic        pready;               // APB ready
  logic        pslverr;              // APB error
  ascr_err_t   err_events;           // Error event pulses
  logic        headphone_select_pin; // Headphone select pin
  ascr_ctl_t   ctl;                  // Decoded control
  ascr_fmt_t   fmt;                  // Decoded format
  logic        irq;                  // Level interrupt
  int          mismatches;           // Failed comparisons
  int          tests_run;            // Comparisons made
  int          cycles;               // Clock cycles since start
  logic [31:0] rd;                   // Last read data
  logic        er;                   // Last slave error

  ////////////////////////////////////////////////////////////////////////////////
  // Format codes with expected justification, length (0 = not checked)
  logic [4:0]  fc [12] = '{FMT_RJ16, FMT_RJ20, FMT_RJ24, FMT_I2S16, FMT_I2S20, FMT_I2S24,
                           FMT_LJ16, FMT_LJ20, FMT_LJ24, FMT_RJ18, FMT_I2S32F, FMT_LJ32F};
  ascr_just_t  fj [12] = '{JUST_RIGHT, JUST_RIGHT, JUST_RIGHT, JUST_I2S, JUST_I2S, JUST_I2S,
                           JUST_LEFT, JUST_LEFT, JUST_LEFT, JUST_RIGHT, JUST_I2S, JUST_LEFT};
  logic [4:0]  fw [12] = '{WL16, WL20, WL24, WL16, WL20, WL24,
                           WL16, WL20, WL24, WL18, WL16, 5'h00};

  ascr_regs DUT (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .err_events(err_events), .headphone_select_pin(headphone_select_pin),
    .ctl(ctl), .fmt(fmt), .irq(irq)
  );

  // Clock generator
  always #50 clock = ~clock;

  // Hang guard, far above the expected run length
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare one value, count it, report a miss
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n < 50, 1'b1, "pready wait");
  endtask : apb

  // Write then let the decode flops settle
  task automatic wreg(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
    repeat (4) @(posedge clock);
  endtask : wreg

  // Read and compare a register word, no error expected
  task automatic rchk(input logic [11:0] a, input logic [7:0] e, input string what);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e}, what);
    chk(er, 1'b0, "pslverr");
  endtask : rchk

  // One-cycle error event pulse
  task automatic pulse(input ascr_err_t e);
    @(posedge clock);
    err_events <= e;
    @(posedge clock);
    err_events <= '0;
    @(negedge clock);
  endtask : pulse

  // Pin change, waited through the synchroniser
  task automatic pin(input logic v);
    @(posedge clock);
    headphone_select_pin <= v;
    repeat (6) @(posedge clock);
  endtask : pin

  // Verdict and end of run
  task automatic summarize();
    $display("counts: tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values of registers and decoded outputs
  task automatic t_reset();
    rchk(ADDR_IDENT, IDENT_CODE, "ident");
    rchk(ADDR_ERR, 8'h00, "err");
    rchk(ADDR_SYS1, 8'ha0, "sys1");
    rchk(ADDR_FMT, 8'h05, "fmt");
    rchk(ADDR_SYS2, 8'h40, "sys2");
    chk(ctl.dc_block_en, 1'b1, "dcblk");
    chk(ctl.hard_unmute, 1'b1, "hardum");
    chk(ctl.autodetect_en, 1'b1, "auto");
    chk(ctl.soft_start_en, 1'b1, "soft");
    chk(ctl.deemph, DEEM_NONE, "deem");
    chk(ctl.play, 1'b0, "play");
    chk(ctl.outputs_valid, 1'b0, "valid");
    chk(fmt.just, JUST_I2S, "just");
    chk(fmt.word_len, WL24, "wl");
    chk(irq, 1'b0, "irq");
    $display("test reset done");
  endtask : t_reset

  // Read-only ident, reserved bits, unmapped address
  task automatic t_reserved();
    wreg(ADDR_IDENT, 8'hff);
    rchk(ADDR_IDENT, IDENT_CODE, "ident ro");
    wreg(ADDR_SYS1, 8'hff);
    rchk(ADDR_SYS1, SYS1_MASK, "sys1 rsv");
    wreg(ADDR_FMT, 8'hff);
    rchk(ADDR_FMT, FMT_MASK, "fmt rsv");
    chk(fmt.reserved, 1'b1, "fmt code rsv");
    wreg(ADDR_SYS2, 8'hff);
    rchk(ADDR_SYS2, SYS2_MASK, "sys2 rsv");
    chk(ctl.mode_rsv, 1'b1, "mode rsv");
    apb(1'b1, 12'h040, 8'h5a);
    chk(er, 1'b1, "unmapped wr err");
    apb(1'b0, 12'h040, 8'h00);
    chk({er, rd}, {1'b1, 32'h0}, "unmapped rd");
    wreg(ADDR_SYS1, 8'ha0);
    wreg(ADDR_FMT, 8'h05);
    wreg(ADDR_SYS2, 8'h40);
    $display("test reserved done");
  endtask : t_reserved

  // First control register fields and every de-emphasis code
  task automatic t_sys1();
    wreg(ADDR_SYS1, 8'h00);
    chk(ctl.dc_block_en, 1'b0, "dcblk off");
    chk(ctl.hard_unmute, 1'b0, "soft um");
    wreg(ADDR_SYS1, 8'h0c);
    chk(ctl.autodetect_en, 1'b0, "auto off");
    chk(ctl.soft_start_en, 1'b0, "soft off");
    for (int d = 0; d < 4; d++) begin
      wreg(ADDR_SYS1, 8'(d));
      chk(ctl.deemph, (d == 1) ? 2'h0 : 2'(d), "deem");
      chk(ctl.deemph_rsv, d == 1, "deem rsv");
    end
    wreg(ADDR_SYS1, 8'ha0);
    $display("test sys1 done");
  endtask : t_sys1

  // Every listed serial format and one reserved code
  task automatic t_format();
    for (int i = 0; i < 12; i++) begin
      wreg(ADDR_FMT, {3'h0, fc[i]});
      chk(fmt.just, fj[i], "fmt just");
      if (fw[i] != 5'h00)
        chk(fmt.word_len, fw[i], "fmt wl");
      chk(fmt.bclk_32fs, i >= 10, "32fs");
      chk(fmt.reserved, 1'b0, "fmt ok");
    end
    wreg(ADDR_FMT, 8'h09);
    chk({fmt.reserved, fmt.word_len}, {1'b1, WL24}, "fmt rsv");
    wreg(ADDR_FMT, 8'h05);
    $display("test format done");
  endtask : t_format

  // Play, configuration and volume source, configuration changed while stopped
  task automatic t_sys2();
    wreg(ADDR_SYS2, 8'h60);
    chk({ctl.play, ctl.outputs_valid, ctl.all_channels}, 3'b001, "stop all");
    wreg(ADDR_SYS2, 8'h20);
    chk({ctl.play, ctl.outputs_valid}, 2'b11, "play all");
    chk(ctl.all_channels, 1'b1, "allch");
    wreg(ADDR_SYS2, 8'h60);
    wreg(ADDR_SYS2, 8'h40);
    wreg(ADDR_SYS2, 8'h00);
    chk({ctl.play, ctl.all_channels}, 2'b10, "play group");
    chk(ctl.hp_vol_own, 1'b1, "hp vol own");
    wreg(ADDR_SYS2, 8'h08);
    chk(ctl.hp_vol_own, 1'b0, "ch vol");
    wreg(ADDR_SYS2, 8'h40);
    $display("test sys2 done");
  endtask : t_sys2

  // Output modes against the headphone select pin
  task automatic t_mode();
    wreg(ADDR_SYS2, 8'h00);
    chk({ctl.hp_active, ctl.spk_mute}, 2'b00, "spk");
    pin(1'b1);
    chk(ctl.hp_active, 1'b1, "spk pin hp");
    wreg(ADDR_SYS2, 8'h02);
    pin(1'b0);
    chk({ctl.hp_active, ctl.spk_mute}, 2'b11, "hp forced");
    wreg(ADDR_SYS2, 8'h0c);
    chk({ctl.line_out, ctl.spk_mute}, 2'b10, "line");
    pin(1'b1);
    chk({ctl.line_out, ctl.spk_mute}, 2'b10, "line pin");
    wreg(ADDR_SYS2, 8'h06);
    chk(ctl.mode_rsv, 1'b1, "mode 11");
    pin(1'b0);
    wreg(ADDR_SYS2, 8'h40);
    $display("test mode done");
  endtask : t_mode

  // Sticky flags, clear by write, mask and interrupt
  task automatic t_errors();
    for (int i = 0; i < 4; i++) begin
      pulse(ascr_err_t'(4'h1 << i));
      repeat (20) @(posedge clock);
      rchk(ADDR_ERR, 8'h08 << i, "flag sticky");
      chk(irq, 1'b0, "irq masked");
      wreg(ADDR_ERR, 8'h00);
      rchk(ADDR_ERR, 8'h00, "flag cleared");
    end
    wreg(ADDR_IRQMASK, 8'h08);
    rchk(ADDR_IRQMASK, 8'h08, "mask");
    pulse(ascr_err_t'(4'h8));
    chk(irq, 1'b0, "irq other masked");
    pulse(ascr_err_t'(4'h1));
    chk(irq, 1'b1, "irq raised");
    wreg(ADDR_ERR, 8'h00);
    chk(irq, 1'b0, "irq cleared");
    $display("test errors done");
  endtask : t_errors

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    err_events = '0;
    headphone_select_pin = 1'b0;
    mismatches = 0;
    tests_run = 0;
    cycles = 0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_reserved();
    t_sys1();
    t_format();
    t_sys2();
    t_mode();
    t_errors();
    summarize();
  end
endmodule : tb_amp_system_control_regs
